// ==== shared/mssx_defs.vh ====
// Purpose: constants for the rotate / subtract / skip / table-read execution block
// Assumes: included by bare name from every design file
// Notes:   register offsets are byte addresses on a 32-bit AHB-Lite bus
//
// What this block does
// RL1: rotl_into_work puts memory rotated left, bit7 to bit0, into work; nothing else changes.
// RL2: rotl_through_carry rotates memory left through carry; only carry changes.
// RL3: rotl_carry_into_work does the same nine-bit rotate into work; memory kept.
// RL4: rotate_right_plain rotates memory right, bit0 to bit7; flags untouched.
// RL5: rotr_into_work puts memory rotated right into work; memory, flags, carry unused.
// RL6: rotr_through_carry rotates right via carry, to memory or work.
// RL7: subtract_with_borrow gives work minus memory minus inverted carry, updates four flags.
// RL8: every subtract clears carry on negative result, sets it on zero or positive.
// RL9: plain subtract takes memory or immediate, no borrow, to work or memory.
// RL10: decrement_and_skip decrements, skips on zero; work form tests work; no flags.
// RL11: increment_and_skip increments, skips on zero; work form keeps memory; no flags.
// RL12: every taken conditional skip costs two instruction cycles through a dummy cycle.
// RL13: set byte writes all ones, set bit forces one bit; no flags.
// RL14: bit_nonzero_skip skips on one, bit zero test skips on zero; nothing written.
// RL15: zero_test_skip skips on zero byte; copy_and_zero_test copies to work first.
// RL16: nibble swap exchanges nibbles; work form leaves memory; no flags.
// RL17: table_read_current_page reads program word in current page to memory and latch.
// RL18: table_read_final_page reads program word in last page to memory and latch.
// RL19: taken skip runs the fetched next instruction as a no-operation, pc passes it.
`ifndef MSSX_DEFS_VH
`define MSSX_DEFS_VH

`define MSSX_A_INSN      8'h00
`define MSSX_A_WORK      8'h04
`define MSSX_A_FLAGS     8'h08
`define MSSX_A_TABLE     8'h0c
`define MSSX_A_PC        8'h10
`define MSSX_A_MEMW      8'h14
`define MSSX_A_ICOUNT    8'h18

`define MSSX_F_OP        4:0
`define MSSX_F_BIT       7:5
`define MSSX_F_ADDR      15:8
`define MSSX_F_IMM       23:16
`define MSSX_F_MDATA     7:0
`define MSSX_F_MADDR     15:8
`define MSSX_F_TPTR      7:0
`define MSSX_F_THIGH     15:8

`define MSSX_FB_C        0
`define MSSX_FB_HC       1
`define MSSX_FB_Z        2
`define MSSX_FB_OVF      3
`define MSSX_FB_BUSY     4
`define MSSX_FB_SKIP     5

`define MSSX_BYTE_ZERO   8'h00
`define MSSX_BYTE_ONES   8'hff
`define MSSX_ONE_BYTE    8'h01

`define MSSX_OP_ROTL_MEM       5'h00
`define MSSX_OP_ROTL_WORK      5'h01
`define MSSX_OP_ROTLC_MEM      5'h02
`define MSSX_OP_ROTLC_WORK     5'h03
`define MSSX_OP_ROTR_MEM       5'h04
`define MSSX_OP_ROTR_WORK      5'h05
`define MSSX_OP_ROTRC_MEM      5'h06
`define MSSX_OP_ROTRC_WORK     5'h07
`define MSSX_OP_SUBB_WORK      5'h08
`define MSSX_OP_SUBB_MEM       5'h09
`define MSSX_OP_SUB_WORK       5'h0a
`define MSSX_OP_SUB_MEM        5'h0b
`define MSSX_OP_SUB_IMM        5'h0c
`define MSSX_OP_DEC_SKIP       5'h0d
`define MSSX_OP_DEC_SKIP_WORK  5'h0e
`define MSSX_OP_INC_SKIP       5'h0f
`define MSSX_OP_INC_SKIP_WORK  5'h10
`define MSSX_OP_SET_BYTE       5'h11
`define MSSX_OP_SET_BIT        5'h12
`define MSSX_OP_BIT_NZ_SKIP    5'h13
`define MSSX_OP_BIT_Z_SKIP     5'h14
`define MSSX_OP_ZERO_SKIP      5'h15
`define MSSX_OP_COPY_ZERO      5'h16
`define MSSX_OP_SWAP_MEM       5'h17
`define MSSX_OP_SWAP_WORK      5'h18
`define MSSX_OP_TBL_CUR        5'h19
`define MSSX_OP_TBL_LAST       5'h1a

`endif

// ==== src/mssx_dmem.v ====
// Purpose: data memory bytes of the core, one write port and one read port
// Assumes: read data is registered, valid the cycle after the address
// Notes:   no reset of contents, as in a real register file ram
`timescale 1ns/1ps
`include "mssx_defs.vh"
module mssx_dmem #(
	parameter AW = 8,
	parameter DW = 8
) (
	input  wire          mclk,
	input  wire          wr_en,
	input  wire [AW-1:0] wr_addr,
	input  wire [DW-1:0] wr_data,
	input  wire [AW-1:0] rd_addr,
	output reg  [DW-1:0] rd_data
);
	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge mclk)
	begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
		rd_data <= mem[rd_addr];
	end
endmodule // mssx_dmem

// ==== src/mssx_alu.v ====
// Purpose: combinational result, flags and skip decision for one instruction
// Assumes: operands are stable for the execute cycle
// Notes:   table reads are finished in the core, this unit handles them in its default case
`timescale 1ns/1ps
`include "mssx_defs.vh"
module mssx_alu (
	input  wire [4:0] op,
	input  wire [7:0] mem_val,
	input  wire [7:0] work_val,
	input  wire [7:0] imm_val,
	input  wire [2:0] bit_sel,
	input  wire       carry_in,
	output reg  [7:0] result,
	output reg        to_work,
	output reg        to_mem,
	output reg        upd_c,
	output reg        upd_arith,
	output reg        c_out,
	output wire       hc_out,
	output wire       z_out,
	output wire       ovf_out,
	output reg        skip
);
	function [7:0] bit_mask;
		input [2:0] sel;
		begin
			bit_mask = `MSSX_ONE_BYTE << sel;
		end
	endfunction

	// borrow form uses the carry as an inverted borrow
	wire       use_imm  = (op == `MSSX_OP_SUB_IMM);
	wire       use_brw  = (op == `MSSX_OP_SUBB_WORK) || (op == `MSSX_OP_SUBB_MEM);
	wire [7:0] sub_b    = use_imm ? imm_val : mem_val;
	wire       sub_cin  = use_brw ? carry_in : 1'b1;
	wire [8:0] diff     = {1'b0, work_val} + {1'b0, ~sub_b} + {8'h00, sub_cin}; // RL7
	wire [4:0] low_diff = {1'b0, work_val[3:0]} + {1'b0, ~sub_b[3:0]} + {4'h0, sub_cin};
	wire [7:0] dec_val  = mem_val - `MSSX_ONE_BYTE;
	wire [7:0] inc_val  = mem_val + `MSSX_ONE_BYTE;

	assign hc_out  = low_diff[4];
	assign z_out   = (diff[7:0] == `MSSX_BYTE_ZERO);
	assign ovf_out = (work_val[7] ^ sub_b[7]) & (diff[7] ^ work_val[7]);

	always @*
	begin
		result    = mem_val;
		to_work   = 1'b0;
		to_mem    = 1'b0;
		upd_c     = 1'b0;
		upd_arith = 1'b0;
		c_out     = carry_in;
		skip      = 1'b0;
		case (op)
			`MSSX_OP_ROTL_MEM:      begin result = {mem_val[6:0], mem_val[7]}; to_mem = 1'b1; end
			`MSSX_OP_ROTL_WORK:     begin result = {mem_val[6:0], mem_val[7]}; to_work = 1'b1; end // RL1
			`MSSX_OP_ROTLC_MEM:     begin result = {mem_val[6:0], carry_in}; to_mem = 1'b1; // RL2
				upd_c = 1'b1; c_out = mem_val[7]; end
			`MSSX_OP_ROTLC_WORK:    begin result = {mem_val[6:0], carry_in}; to_work = 1'b1; // RL3
				upd_c = 1'b1; c_out = mem_val[7]; end
			`MSSX_OP_ROTR_MEM:      begin result = {mem_val[0], mem_val[7:1]}; to_mem = 1'b1; end // RL4
			`MSSX_OP_ROTR_WORK:     begin result = {mem_val[0], mem_val[7:1]}; to_work = 1'b1; end // RL5
			`MSSX_OP_ROTRC_MEM:     begin result = {carry_in, mem_val[7:1]}; to_mem = 1'b1; // RL6
				upd_c = 1'b1; c_out = mem_val[0]; end
			`MSSX_OP_ROTRC_WORK:    begin result = {carry_in, mem_val[7:1]}; to_work = 1'b1; // RL6
				upd_c = 1'b1; c_out = mem_val[0]; end
			`MSSX_OP_SUBB_WORK, `MSSX_OP_SUB_WORK, `MSSX_OP_SUB_IMM:
			begin
				result = diff[7:0]; to_work = 1'b1; upd_arith = 1'b1; // RL9
				upd_c = 1'b1; c_out = diff[8]; // RL8
			end
			`MSSX_OP_SUBB_MEM, `MSSX_OP_SUB_MEM:
			begin
				result = diff[7:0]; to_mem = 1'b1; upd_arith = 1'b1; // RL9
				upd_c = 1'b1; c_out = diff[8]; // RL8
			end
			`MSSX_OP_DEC_SKIP:      begin result = dec_val; to_mem = 1'b1; skip = (dec_val == `MSSX_BYTE_ZERO); end // RL10
			`MSSX_OP_DEC_SKIP_WORK: begin result = dec_val; to_work = 1'b1; skip = (dec_val == `MSSX_BYTE_ZERO); end // RL10
			`MSSX_OP_INC_SKIP:      begin result = inc_val; to_mem = 1'b1; skip = (inc_val == `MSSX_BYTE_ZERO); end // RL11
			`MSSX_OP_INC_SKIP_WORK: begin result = inc_val; to_work = 1'b1; skip = (inc_val == `MSSX_BYTE_ZERO); end // RL11
			`MSSX_OP_SET_BYTE:      begin result = `MSSX_BYTE_ONES; to_mem = 1'b1; end // RL13
			`MSSX_OP_SET_BIT:       begin result = mem_val | bit_mask(bit_sel); to_mem = 1'b1; end // RL13
			`MSSX_OP_BIT_NZ_SKIP:   skip = ((mem_val & bit_mask(bit_sel)) != `MSSX_BYTE_ZERO); // RL14
			`MSSX_OP_BIT_Z_SKIP:    skip = ((mem_val & bit_mask(bit_sel)) == `MSSX_BYTE_ZERO); // RL14
			`MSSX_OP_ZERO_SKIP:     skip = (mem_val == `MSSX_BYTE_ZERO); // RL15
			`MSSX_OP_COPY_ZERO:     begin to_work = 1'b1; skip = (mem_val == `MSSX_BYTE_ZERO); end // RL15
			`MSSX_OP_SWAP_MEM:      begin result = {mem_val[3:0], mem_val[7:4]}; to_mem = 1'b1; end // RL16
			`MSSX_OP_SWAP_WORK:     begin result = {mem_val[3:0], mem_val[7:4]}; to_work = 1'b1; end // RL16
			default:                result = mem_val;
		endcase
	end
endmodule // mssx_alu

// ==== src/mssx_core.v ====
// Purpose: executes one queued instruction on data memory, work register and flags
// Assumes: program memory answers pmem_word in the cycle in which pmem_rd is high
// Notes:   the bus stalls a transfer while an instruction is in flight
//
// Chosen here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "mssx_defs.vh"
module mssx_core #(
	parameter PC_W   = 11,
	parameter WORD_W = 14,
	parameter MEM_AW = 8
) (
	input  wire              mclk,
	input  wire              sys_rst,
	input  wire              hsel,
	input  wire [31:0]       haddr,
	input  wire [1:0]        htrans,
	input  wire              hwrite,
	input  wire [2:0]        hsize,
	input  wire [31:0]       hwdata,
	input  wire              hready,
	output reg  [31:0]       hrdata,
	output wire              hreadyout,
	output wire              hresp,
	output reg  [PC_W-1:0]   pmem_addr,
	output reg               pmem_rd,
	input  wire [WORD_W-1:0] pmem_word
);
	localparam ST_IDLE  = 2'd0;
	localparam ST_FETCH = 2'd1;
	localparam ST_EXEC  = 2'd2;
	localparam ST_DUMMY = 2'd3;
	localparam [PC_W-1:0] PC_ONE = 1;
	localparam [31:0] CNT_ONE = 1;

	reg  [1:0]        state_r;
	reg  [1:0]        state_nxt;
	reg  [23:0]       insn_r;
	reg  [7:0]        work_r;
	reg               c_r;
	reg               hc_r;
	reg               z_r;
	reg               ovf_r;
	reg               skip_r;
	reg  [7:0]        tptr_r;
	reg  [7:0]        thigh_r;
	reg  [PC_W-1:0]   pc_r;
	reg  [31:0]       icount_r;
	reg               dph_r;
	reg               dph_wr_r;
	reg  [7:0]        dph_addr_r;
	reg               rd_done_r;
	reg  [31:0]       rd_mux;

	wire [7:0]        mem_rdata;
	wire [7:0]        alu_res;
	wire              alu_to_work;
	wire              alu_to_mem;
	wire              alu_upd_c;
	wire              alu_upd_arith;
	wire              alu_c;
	wire              alu_hc;
	wire              alu_z;
	wire              alu_ovf;
	wire              alu_skip;

	wire [4:0] op      = insn_r[`MSSX_F_OP];
	wire       is_tbl  = (op == `MSSX_OP_TBL_CUR) || (op == `MSSX_OP_TBL_LAST);
	wire       busy    = (state_r != ST_IDLE);
	wire       aph     = hsel && htrans[1] && hready;
	wire       xfer_end = dph_r && hreadyout;
	wire       bus_wr  = xfer_end && dph_wr_r;
	wire       insn_go = bus_wr && (dph_addr_r == `MSSX_A_INSN);
	wire       memw_go = bus_wr && (dph_addr_r == `MSSX_A_MEMW);
	wire       exec    = (state_r == ST_EXEC);

	// a table read delivers its low byte to memory; the other writers are the bus memory write and the alu
	wire [7:0] tbl_low  = pmem_word[7:0];
	wire [7:0] tbl_high = {{(16 - WORD_W){1'b0}}, pmem_word[WORD_W-1:8]};
	wire       mem_we   = memw_go || (exec && (alu_to_mem || is_tbl));
	wire [7:0] mem_wdat = memw_go ? hwdata[`MSSX_F_MDATA] : (is_tbl ? tbl_low : alu_res);
	wire [7:0] mem_wadr = memw_go ? hwdata[`MSSX_F_MADDR] : insn_r[`MSSX_F_ADDR];

	// reads cost one wait state so that hrdata can come from a flip-flop
	assign hreadyout = !dph_r || (!busy && (dph_wr_r || rd_done_r));
	assign hresp     = 1'b0;

	mssx_dmem #(
		.AW      (MEM_AW),
		.DW      (8)
	) u_dmem (
		.mclk    (mclk),
		.wr_en   (mem_we),
		.wr_addr (mem_wadr[MEM_AW-1:0]),
		.wr_data (mem_wdat),
		.rd_addr (insn_r[8 + MEM_AW - 1:8]),
		.rd_data (mem_rdata)
	);

	mssx_alu u_alu (
		.op        (op),
		.mem_val   (mem_rdata),
		.work_val  (work_r),
		.imm_val   (insn_r[`MSSX_F_IMM]),
		.bit_sel   (insn_r[`MSSX_F_BIT]),
		.carry_in  (c_r),
		.result    (alu_res),
		.to_work   (alu_to_work),
		.to_mem    (alu_to_mem),
		.upd_c     (alu_upd_c),
		.upd_arith (alu_upd_arith),
		.c_out     (alu_c),
		.hc_out    (alu_hc),
		.z_out     (alu_z),
		.ovf_out   (alu_ovf),
		.skip      (alu_skip)
	);

	always @*
	begin
		rd_mux = 32'h0000_0000;
		case (dph_addr_r)
			`MSSX_A_INSN:   rd_mux = {8'h00, insn_r};
			`MSSX_A_WORK:   rd_mux = {24'h00_0000, work_r};
			`MSSX_A_FLAGS:  rd_mux = {26'h000_0000, skip_r, busy, ovf_r, z_r, hc_r, c_r};
			`MSSX_A_TABLE:  rd_mux = {16'h0000, thigh_r, tptr_r};
			`MSSX_A_PC:     rd_mux = {{(32 - PC_W){1'b0}}, pc_r};
			`MSSX_A_ICOUNT: rd_mux = icount_r;
			default:        rd_mux = 32'h0000_0000;
		endcase
	end

	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:  if (insn_go) state_nxt = ST_FETCH;
			ST_FETCH: state_nxt = ST_EXEC;
			ST_EXEC:  state_nxt = (alu_skip && !is_tbl) ? ST_DUMMY : ST_IDLE; // RL12
			ST_DUMMY: state_nxt = ST_IDLE;
			default:  state_nxt = ST_IDLE;
		endcase
	end

	// bus address and data phase tracking
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			dph_r      <= 1'b0;
			dph_wr_r   <= 1'b0;
			dph_addr_r <= `MSSX_BYTE_ZERO;
			rd_done_r  <= 1'b0;
			hrdata     <= 32'h0000_0000;
		end
		else
		begin
			if (!dph_r || hreadyout)
			begin
				dph_r      <= aph;
				dph_wr_r   <= hwrite;
				dph_addr_r <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : `MSSX_BYTE_ONES;
				rd_done_r  <= 1'b0;
			end
			else if (!busy && !dph_wr_r && !rd_done_r)
			begin
				hrdata    <= rd_mux;
				rd_done_r <= 1'b1;
			end
		end
	end

	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			state_r   <= ST_IDLE;
			insn_r    <= 24'h00_0000;
			work_r    <= `MSSX_BYTE_ZERO;
			c_r       <= 1'b0;
			hc_r      <= 1'b0;
			z_r       <= 1'b0;
			ovf_r     <= 1'b0;
			skip_r    <= 1'b0;
			tptr_r    <= `MSSX_BYTE_ZERO;
			thigh_r   <= `MSSX_BYTE_ZERO;
			pc_r      <= {PC_W{1'b0}};
			icount_r  <= 32'h0000_0000;
			pmem_addr <= {PC_W{1'b0}};
			pmem_rd   <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			pmem_rd <= 1'b0;
			if (insn_go)
				insn_r <= hwdata[23:0];
			if (bus_wr && dph_addr_r == `MSSX_A_WORK)
				work_r <= hwdata[7:0];
			if (bus_wr && dph_addr_r == `MSSX_A_FLAGS)
			begin
				c_r  <= hwdata[`MSSX_FB_C];
				hc_r  <= hwdata[`MSSX_FB_HC];
				z_r   <= hwdata[`MSSX_FB_Z];
				ovf_r <= hwdata[`MSSX_FB_OVF];
			end
			if (bus_wr && dph_addr_r == `MSSX_A_TABLE)
				tptr_r <= hwdata[`MSSX_F_TPTR];
			if (bus_wr && dph_addr_r == `MSSX_A_PC)
				pc_r <= hwdata[PC_W-1:0];
			if (state_r == ST_FETCH && is_tbl)
			begin
				pmem_rd <= 1'b1;
				if (op == `MSSX_OP_TBL_CUR)
					pmem_addr <= {pc_r[PC_W-1:8], tptr_r}; // RL17
				else
					pmem_addr <= {{(PC_W - 8){1'b1}}, tptr_r}; // RL18
			end
			if (exec)
			begin
				pc_r     <= pc_r + PC_ONE;
				icount_r <= icount_r + CNT_ONE;
				skip_r   <= alu_skip && !is_tbl;
				if (is_tbl)
					thigh_r <= tbl_high; // RL17 RL18
				else if (alu_to_work)
					work_r <= alu_res; // RL1 RL3 RL5 RL15 RL16
				if (!is_tbl && alu_upd_c)
					c_r <= alu_c; // RL8
				if (!is_tbl && alu_upd_arith)
				begin
					hc_r  <= alu_hc; // RL7
					z_r   <= alu_z;
					ovf_r <= alu_ovf;
				end
			end
			// the following word was already fetched; it retires as a no-operation
			if (state_r == ST_DUMMY)
			begin
				pc_r     <= pc_r + PC_ONE; // RL19
				icount_r <= icount_r + CNT_ONE; // RL12
			end
		end
	end
endmodule // mssx_core

// ==== verification/mssx_core_sva.sv ====
// Purpose: port-level checks on bus answers and program memory fetches of the core
// Assumes: hready is tied to hreadyout; tracks the table pointer from bus writes
// Notes:   instruction writes are recognised at the end of their data phase
`timescale 1ns/1ps
`include "mssx_defs.vh"
module mssx_core_sva #(
	parameter PC_W   = 11,
	parameter WORD_W = 14,
	parameter MEM_AW = 8
) (
	input wire              mclk,
	input wire              sys_rst,
	input wire              hsel,
	input wire [31:0]       haddr,
	input wire [1:0]        htrans,
	input wire              hwrite,
	input wire [2:0]        hsize,
	input wire [31:0]       hwdata,
	input wire              hready,
	input wire [31:0]       hrdata,
	input wire              hreadyout,
	input wire              hresp,
	input wire [PC_W-1:0]   pmem_addr,
	input wire              pmem_rd,
	input wire [WORD_W-1:0] pmem_word
);
	reg        dpi_r;
	reg        dpt_r;
	reg  [7:0] tptr_r;
	wire       take = hsel & htrans[1] & hready;
	wire       go   = dpi_r & hreadyout;
	wire       cur  = hwdata[4:0] == `MSSX_OP_TBL_CUR;
	wire       last = hwdata[4:0] == `MSSX_OP_TBL_LAST;
	// pointer mirror lets fetch addresses be judged without peeking inside
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			dpi_r  <= 1'b0;
			dpt_r  <= 1'b0;
			tptr_r <= 8'h00;
		end
		else
		begin
			if (take)
			begin
				dpi_r <= hwrite & (haddr == 32'h0);
				dpt_r <= hwrite & (haddr == 32'hc);
			end
			else if (hreadyout)
			begin
				dpi_r <= 1'b0;
				dpt_r <= 1'b0;
			end
			if (dpt_r & hreadyout)
				tptr_r <= hwdata[7:0];
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	property p_resp_okay; hresp == 1'b0; endproperty
	a_resp_okay: assert property (p_resp_okay) else $error("bus response not okay");
	property p_read_wait; take && !hwrite |=> !hreadyout; endproperty
	a_read_wait: assert property (p_read_wait) else $error("read answered without wait");
	property p_rd_pulse; pmem_rd |=> !pmem_rd; endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("fetch strobe longer than one cycle");
	property p_tbl_fetch; go && (cur || last) |-> ##2 pmem_rd; endproperty
	a_tbl_fetch: assert property (p_tbl_fetch) else $error("table read did not fetch");
	property p_no_fetch; go && !cur && !last |-> ##1 !pmem_rd [*3]; endproperty
	a_no_fetch: assert property (p_no_fetch) else $error("fetch without table read");
	property p_cur_addr; go && cur |-> ##2 pmem_addr[7:0] == tptr_r; endproperty
	a_cur_addr: assert property (p_cur_addr) else $error("current page fetch address wrong");
	property p_last_page; go && last |-> ##2 pmem_addr == {{(PC_W-8){1'b1}}, tptr_r}; endproperty
	a_last_page: assert property (p_last_page) else $error("last page fetch address wrong");
	property p_addr_hold; pmem_rd |=> $stable(pmem_addr); endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("fetch address moved during answer");
endmodule // mssx_core_sva

bind mssx_core mssx_core_sva #(.PC_W(PC_W), .WORD_W(WORD_W), .MEM_AW(MEM_AW)) u_sva (.mclk(mclk),
	.sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .pmem_word(pmem_word));

// ==== verification/mssx_pmem_model.sv ====
// Purpose: program memory seen by the core's table reads
// Assumes: word stands during the cycle in which the strobe is high
// Notes:   word content is a fixed function of the address; it toggles outside the answer
`timescale 1ns/1ps
module mssx_pmem_model (
	input  wire        mclk,
	input  wire [10:0] pmem_addr,
	input  wire        pmem_rd,
	output wire [13:0] pmem_word
);
	reg [13:0] idle_r;
	initial idle_r = 14'h0000;
	// the core samples the word at the edge that ends its strobe, so the answer must stand while it is high
	// toggling when idle keeps a stale word from passing for an answer
	always @(posedge mclk)
	begin
		idle_r <= ~idle_r;
	end
	assign pmem_word = pmem_rd ? {pmem_addr[10:8], 3'h5, ~pmem_addr[7:0]} : idle_r;
endmodule // mssx_pmem_model

// ==== verification/tb_top.sv ====
// Purpose: runs each instruction through the bus and checks work, flags, pc, count, memory
// Assumes: single bus transfers, memory byte 0x20 used as operand
// Notes:   data memory is read back by a copy-and-test instruction into work
`timescale 1ns/1ps
`include "mssx_defs.vh"
module tb_top;
	reg         mclk;
	reg         sys_rst;
	reg         hsel;
	reg         hwrite;
	reg  [31:0] haddr;
	reg  [31:0] hwdata;
	reg  [1:0]  htrans;
	reg  [2:0]  hsize;
	wire [31:0] hrdata;
	wire        hreadyout;
	wire        hresp;
	wire        pmem_rd;
	wire [10:0] pmem_addr;
	wire [13:0] pmem_word;
	integer     failures;
	integer     n_compared;
	integer     cyc;
	reg  [31:0] rd;
	reg  [31:0] i0;
	mssx_core u_dut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .pmem_word(pmem_word));
	mssx_pmem_model u_pmem (.mclk(mclk), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .pmem_word(pmem_word));
	task report_and_stop;
	begin
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	task bus_wait;
	begin
		@(posedge mclk);
		while (hreadyout !== 1'b1)
			@(posedge mclk);
	end
	endtask
	task ahb(input w, input [11:0] a, input [31:0] d);
	begin
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		bus_wait;
		htrans <= 2'b00;
		hwdata <= d;
		bus_wait;
		rd = hrdata;
	end
	endtask
	task chk(input [47:0] nm, input [31:0] e, input [31:0] g);
	begin
		n_compared = n_compared + 1;
		if (g !== e)
		begin
			failures = failures + 1;
			$display("[ERR] %0s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	// operand byte, work and flags are loaded fresh so every case stands alone
	task run(input [4:0] op, input [2:0] b, input [7:0] m, w, input [3:0] f, input [7:0] em, ew,
		input [3:0] ef, input sk);
	begin
		ahb(1'b1, 12'h014, {16'h0, 8'h20, m});
		ahb(1'b1, 12'h004, {24'h0, w});
		ahb(1'b1, 12'h008, {28'h0, f});
		ahb(1'b1, 12'h010, 32'h2f0);
		ahb(1'b1, 12'h00c, 32'h5a);
		ahb(1'b0, 12'h018, 32'h0);
		i0 = rd;
		ahb(1'b1, 12'h000, {8'h0, 8'h50, 8'h20, b, op});
		ahb(1'b0, 12'h004, 32'h0);
		chk("work", {24'h0, ew}, rd);
		ahb(1'b0, 12'h008, 32'h0);
		chk("flags", {26'h0, sk, 1'b0, ef}, rd);
		ahb(1'b0, 12'h010, 32'h0);
		chk("pc", 32'h2f1 + {31'h0, sk}, rd);
		ahb(1'b0, 12'h018, 32'h0);
		chk("icount", i0 + 32'h1 + {31'h0, sk}, rd);
		ahb(1'b1, 12'h000, {16'h0, 8'h20, 3'h0, `MSSX_OP_COPY_ZERO});
		ahb(1'b0, 12'h004, 32'h0);
		chk("mem", {24'h0, em}, rd);
	end
	endtask
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cyc = cyc + 1;
		if (cyc == 20000)
		begin
			failures = failures + 1;
			report_and_stop;
		end
	end
	initial
	begin
		cyc = 0;
		failures = 0;
		n_compared = 0;
		sys_rst = 1'b1;
		hsel = 1'b1;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'b00;
		hsize = 3'h2;
		repeat (5) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		for (i0 = 0; i0 < 32'h1c; i0 = i0 + 4)
		begin
			ahb(1'b0, i0[11:0], 32'h0);
			chk("reset", 32'h0, rd);
		end
		ahb(1'b1, 12'h100, 32'hffff_ffff);
		ahb(1'b0, 12'h100, 32'h0);
		chk("unmap", 32'h0, rd);
		ahb(1'b1, 12'h008, 32'h3f);
		ahb(1'b0, 12'h008, 32'h0);
		chk("flagro", 32'hf, rd);
		run(5'h00, 3'h0, 8'h96, 8'h3c, 4'h5, 8'h2d, 8'h3c, 4'h5, 1'b0);
		run(5'h01, 3'h0, 8'h96, 8'h3c, 4'h5, 8'h96, 8'h2d, 4'h5, 1'b0);
		run(5'h02, 3'h0, 8'h96, 8'h3c, 4'ha, 8'h2c, 8'h3c, 4'hb, 1'b0);
		run(5'h03, 3'h0, 8'h16, 8'h3c, 4'h5, 8'h16, 8'h2d, 4'h4, 1'b0);
		run(5'h04, 3'h0, 8'h97, 8'h3c, 4'hf, 8'hcb, 8'h3c, 4'hf, 1'b0);
		run(5'h05, 3'h0, 8'h97, 8'h3c, 4'h4, 8'h97, 8'hcb, 4'h4, 1'b0);
		run(5'h06, 3'h0, 8'h97, 8'h3c, 4'h4, 8'h4b, 8'h3c, 4'h5, 1'b0);
		run(5'h07, 3'h0, 8'h96, 8'h3c, 4'h5, 8'h96, 8'hcb, 4'h4, 1'b0);
		run(5'h08, 3'h0, 8'h96, 8'h3c, 4'h5, 8'h96, 8'ha6, 4'ha, 1'b0);
		run(5'h09, 3'h0, 8'h3b, 8'h3c, 4'h4, 8'h00, 8'h3c, 4'h7, 1'b0);
		run(5'h0a, 3'h0, 8'h3d, 8'h3c, 4'hf, 8'h3d, 8'hff, 4'h0, 1'b0);
		run(5'h0b, 3'h0, 8'h3c, 8'h3c, 4'h0, 8'h00, 8'h3c, 4'h7, 1'b0);
		run(5'h0c, 3'h0, 8'h96, 8'h3c, 4'hd, 8'h96, 8'hec, 4'h2, 1'b0);
		run(5'h0d, 3'h0, 8'h01, 8'h3c, 4'h5, 8'h00, 8'h3c, 4'h5, 1'b1);
		run(5'h0d, 3'h0, 8'h02, 8'h3c, 4'h5, 8'h01, 8'h3c, 4'h5, 1'b0);
		run(5'h0e, 3'h0, 8'h01, 8'h3c, 4'h5, 8'h01, 8'h00, 4'h5, 1'b1);
		run(5'h0f, 3'h0, 8'hff, 8'h3c, 4'h5, 8'h00, 8'h3c, 4'h5, 1'b1);
		run(5'h10, 3'h0, 8'hfe, 8'h3c, 4'h5, 8'hfe, 8'hff, 4'h5, 1'b0);
		run(5'h11, 3'h0, 8'h00, 8'h3c, 4'ha, 8'hff, 8'h3c, 4'ha, 1'b0);
		run(5'h12, 3'h5, 8'h81, 8'h3c, 4'ha, 8'ha1, 8'h3c, 4'ha, 1'b0);
		run(5'h13, 3'h3, 8'h08, 8'h3c, 4'h5, 8'h08, 8'h3c, 4'h5, 1'b1);
		run(5'h13, 3'h3, 8'hf7, 8'h3c, 4'h5, 8'hf7, 8'h3c, 4'h5, 1'b0);
		run(5'h14, 3'h3, 8'hf7, 8'h3c, 4'h5, 8'hf7, 8'h3c, 4'h5, 1'b1);
		run(5'h14, 3'h3, 8'h08, 8'h3c, 4'h5, 8'h08, 8'h3c, 4'h5, 1'b0);
		run(5'h15, 3'h0, 8'h00, 8'h3c, 4'h5, 8'h00, 8'h3c, 4'h5, 1'b1);
		run(5'h15, 3'h0, 8'h80, 8'h3c, 4'h5, 8'h80, 8'h3c, 4'h5, 1'b0);
		run(5'h16, 3'h0, 8'h00, 8'h3c, 4'h5, 8'h00, 8'h00, 4'h5, 1'b1);
		run(5'h16, 3'h0, 8'h5a, 8'h3c, 4'h5, 8'h5a, 8'h5a, 4'h5, 1'b0);
		run(5'h17, 3'h0, 8'h96, 8'h3c, 4'h5, 8'h69, 8'h3c, 4'h5, 1'b0);
		run(5'h18, 3'h0, 8'h96, 8'h3c, 4'h5, 8'h96, 8'h69, 4'h5, 1'b0);
		run(5'h19, 3'h0, 8'h00, 8'h3c, 4'h5, 8'ha5, 8'h3c, 4'h5, 1'b0);
		ahb(1'b0, 12'h00c, 32'h0);
		chk("table", 32'h155a, rd);
		run(5'h1a, 3'h0, 8'h00, 8'h3c, 4'h5, 8'ha5, 8'h3c, 4'h5, 1'b0);
		ahb(1'b0, 12'h00c, 32'h0);
		chk("table", 32'h3d5a, rd);
		report_and_stop;
	end
endmodule // tb_top
